// file: include/nvsram_ctrl_pkg.sv
// Constants for the non-volatile SRAM sequence controller.
// Assumes a 40 MHz system clock and a parallel asynchronous SRAM bus.
package nvsram_ctrl_pkg;

  // ------------------------------------------------------------------
  // Device bus widths
  // ------------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;

  // ------------------------------------------------------------------
  // Command address prefix and selectors
  // ------------------------------------------------------------------
  localparam logic [18:0] SEQ_ADDR_1   = 19'h04e38;
  localparam logic [18:0] SEQ_ADDR_2   = 19'h0b1c7;
  localparam logic [18:0] SEQ_ADDR_3   = 19'h083e0;
  localparam logic [18:0] SEQ_ADDR_4   = 19'h07c1f;
  localparam logic [18:0] SEQ_ADDR_5   = 19'h0703f;
  localparam logic [18:0] CMD_STORE    = 19'h08fc0;
  localparam logic [18:0] CMD_RECALL   = 19'h04c63;
  localparam logic [18:0] CMD_AS_OFF   = 19'h08b45;
  localparam logic [18:0] CMD_AS_ON    = 19'h04b46;

  // ------------------------------------------------------------------
  // Wishbone register map (word addresses, byte address = 4 * index)
  // ------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_RDATA  = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;

  // CTRL fields: bit 0 go, bits 3:1 operation code
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam logic [2:0] OP_READ      = 3'h0;
  localparam logic [2:0] OP_WRITE     = 3'h1;
  localparam logic [2:0] OP_STORE     = 3'h2;
  localparam logic [2:0] OP_RECALL    = 3'h3;
  localparam logic [2:0] OP_AS_OFF    = 3'h4;
  localparam logic [2:0] OP_AS_ON     = 3'h5;

  // STATUS fields
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_DEVB_BIT  = 1;
  localparam int ST_NEED_BIT  = 2;
  localparam int ST_ERR_BIT   = 3;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ        = 40;
  localparam int ACCESS_NS      = 50;
  localparam int ACCESS_CYC     = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVER_NS     = 25;
  localparam int RECOVER_CYC    = (RECOVER_NS * CLK_MHZ + 999) / 1000;
  // Cycles before the synced busy level is trusted; covers the 4-flop lag
  localparam int BUSY_SETTLE_CYC = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_WAITB  = 3'b001,
    ST_ACTIVE = 3'b011,
    ST_GAP    = 3'b010,
    ST_NEXT   = 3'b110
  } cyc_state_type;

endpackage

// file: rtl/nvsram_pin_sync.sv
// Three-stage synchroniser for device pins into the clk_i domain.
// Assumes the input is asynchronous; output changes once stages 2 and 3
// agree.
`timescale 1ns/1ps
module nvsram_pin_sync
#(
  parameter int          W     = 1,
  parameter logic [15:0] INIT  = 16'hffff
)
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg <= INIT[W-1:0];
      s2_reg <= INIT[W-1:0];
      s3_reg <= INIT[W-1:0];
    end
    else
    begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          level_o[g] <= INIT[g];
        else if (s2_reg[g] == s3_reg[g])
          level_o[g] <= s3_reg[g];
      end
    end
  endgenerate

endmodule

// file: rtl/nvsram_sequence_controller.sv
// Host-side controller that drives an asynchronous non-volatile SRAM:
// plain reads/writes plus the six-read store/recall/auto-store sequences.
// Assumes software on classic Wishbone and the device pins outside.
`timescale 1ns/1ps

// Overview of operation
// - Issue prefix reads 4E38, B1C7, 83E0
// - Then read 7C1F and 703F
// - Write enable high in all command reads
// - After auto-store change, set the need-store status bit (no store issued)
module nvsram_sequence_controller
(
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic [3:0]                          wb_adr_i,
  input  wire logic [31:0]                         wb_dat_i,
  output logic      [31:0]                         wb_dat_o,
  input  wire logic                                wb_we_i,
  input  wire logic [3:0]                          wb_sel_i,
  input  wire logic                                wb_cyc_i,
  input  wire logic                                wb_stb_i,
  output logic                                     wb_ack_o,
  output logic      [nvsram_ctrl_pkg::ADDR_W-1:0]  mem_addr_o,
  input  wire logic [nvsram_ctrl_pkg::DATA_W-1:0]  mem_dq_i,
  output logic      [nvsram_ctrl_pkg::DATA_W-1:0]  mem_dq_o,
  output logic                                     mem_dq_oe_o,
  output logic                                     mem_chip_en_n_o,
  output logic                                     mem_out_en_n_o,
  output logic                                     mem_write_en_n_o,
  output logic                                     upper_byte_enable_n_o,
  output logic                                     lower_byte_enable_n_o,
  input  wire logic                                store_busy_n_i,
  output logic                                     store_busy_n_o,
  output logic                                     store_busy_n_oe_o
);
  import nvsram_ctrl_pkg::*;

  // ------------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------------
  logic [15:0]        ctrl_reg;
  logic [18:0]        addr_reg;
  logic [15:0]        wdata_reg;
  logic [15:0]        rdata_reg;
  logic               err_reg;
  logic               need_store_reg;
  logic               busy_reg;
  logic               hold_reg;
  cyc_state_type      state_reg;
  logic [2:0]         step_reg;
  logic [2:0]         op_reg;
  logic [7:0]         cnt_reg;
  logic               busy_n_sync;
  logic               go;
  logic               is_cmd;
  logic               last_step;
  logic [18:0]        step_addr;
  logic [18:0]        sel_addr;

  nvsram_pin_sync #(.W(1), .INIT(16'hffff)) u_busy_sync
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (store_busy_n_i),
    .level_o (busy_n_sync)
  );

  assign go        = ctrl_reg[CTRL_GO_BIT];
  assign is_cmd    = (op_reg >= OP_STORE);
  assign last_step = !is_cmd || (step_reg == 3'd5);

  // ------------------------------------------------------------------
  // Wishbone slave: one wait state, ack drops after one cycle
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg  <= CTRL_RESET;
      addr_reg  <= '0;
      wdata_reg <= '0;
    end
    else
    begin
      if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !busy_reg)
      begin
        if (wb_adr_i == REG_CTRL && wb_sel_i[0])
          ctrl_reg <= {8'h00, wb_dat_i[7:0]};
        else if (wb_adr_i == REG_ADDR)
          addr_reg <= wb_dat_i[18:0];
        else if (wb_adr_i == REG_WDATA)
          wdata_reg <= wb_dat_i[15:0];
      end
      if (state_reg == ST_IDLE && go)
        ctrl_reg[CTRL_GO_BIT] <= 1'b0;
    end
  end

  always_comb
  begin
    wb_dat_o = 32'h00000000;
    if (wb_adr_i == REG_CTRL)
      wb_dat_o = {16'h0000, ctrl_reg};
    else if (wb_adr_i == REG_ADDR)
      wb_dat_o = {13'h0000, addr_reg};
    else if (wb_adr_i == REG_WDATA)
      wb_dat_o = {16'h0000, wdata_reg};
    else if (wb_adr_i == REG_RDATA)
      wb_dat_o = {16'h0000, rdata_reg};
    else if (wb_adr_i == REG_STATUS)
      wb_dat_o = {28'h0000000, err_reg, need_store_reg,
                  !busy_n_sync, busy_reg};
  end

  // ------------------------------------------------------------------
  // Address of the current step
  // ------------------------------------------------------------------
  always_comb
  begin
    case (op_reg)
      OP_STORE:  sel_addr = CMD_STORE;
      OP_RECALL: sel_addr = CMD_RECALL;
      OP_AS_OFF: sel_addr = CMD_AS_OFF;
      OP_AS_ON:  sel_addr = CMD_AS_ON;
      default:   sel_addr = addr_reg;
    endcase
    case (step_reg)
      3'd0:    step_addr = is_cmd ? SEQ_ADDR_1 : addr_reg;
      3'd1:    step_addr = SEQ_ADDR_2;
      3'd2:    step_addr = SEQ_ADDR_3;
      3'd3:    step_addr = SEQ_ADDR_4;
      3'd4:    step_addr = SEQ_ADDR_5;
      default: step_addr = sel_addr;
    endcase
  end

  // ------------------------------------------------------------------
  // Bus cycle sequencer
  // ------------------------------------------------------------------
  // Sequence runs back to back with no other access in between, since
  // the Wishbone side cannot start a cycle while busy.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_WAITB;
      step_reg  <= 3'd0;
      op_reg    <= OP_READ;
      cnt_reg   <= 8'h00;
      busy_reg  <= 1'b1;
      hold_reg  <= 1'b1;
      err_reg   <= 1'b0;
      rdata_reg <= '0;
      need_store_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (go)
          begin
            op_reg    <= ctrl_reg[CTRL_OP_LSB +: 3];
            step_reg  <= 3'd0;
            busy_reg  <= 1'b1;
            err_reg   <= 1'b0;
            state_reg <= ST_WAITB;
          end
        end
        ST_WAITB:
        begin
          // Busy arrives four flops late; let it fall before trusting it
          if (cnt_reg != 8'hff)
            cnt_reg <= cnt_reg + 8'h01;
          if (busy_n_sync && cnt_reg >= 8'(BUSY_SETTLE_CYC))
          begin
            cnt_reg  <= 8'h00;
            hold_reg <= 1'b0;
            if (hold_reg)
            begin
              busy_reg  <= 1'b0;
              state_reg <= ST_IDLE;
            end
            else
              state_reg <= ST_ACTIVE;
          end
        end
        ST_ACTIVE:
        begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == 8'(ACCESS_CYC - 1))
          begin
            if (op_reg == OP_READ)
              rdata_reg <= mem_dq_i;
            cnt_reg   <= 8'h00;
            state_reg <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg >= 8'(RECOVER_CYC - 1))
            state_reg <= ST_NEXT;
        end
        default:
        begin
          cnt_reg <= 8'h00;
          if (last_step)
          begin
            busy_reg  <= 1'b0;
            step_reg  <= 3'd0;
            state_reg <= (is_cmd && op_reg <= OP_RECALL) ? ST_WAITB
                                                         : ST_IDLE;
            if (op_reg == OP_AS_OFF || op_reg == OP_AS_ON)
              need_store_reg <= 1'b1;
            else if (op_reg == OP_STORE)
              need_store_reg <= 1'b0;
            if (is_cmd && op_reg <= OP_RECALL)
            begin
              busy_reg <= 1'b1;
              hold_reg <= 1'b1;
              op_reg   <= OP_READ;
              step_reg <= 3'd0;
            end
          end
          else
          begin
            step_reg  <= step_reg + 3'd1;
            state_reg <= ST_ACTIVE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Pin drive, registered
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mem_addr_o            <= '0;
      mem_dq_o              <= '0;
      mem_dq_oe_o           <= 1'b0;
      mem_chip_en_n_o       <= 1'b1;
      mem_out_en_n_o        <= 1'b1;
      mem_write_en_n_o      <= 1'b1;
      upper_byte_enable_n_o <= 1'b1;
      lower_byte_enable_n_o <= 1'b1;
    end
    else
    begin
      mem_addr_o <= step_addr;
      mem_dq_o   <= wdata_reg;
      if (state_reg == ST_ACTIVE && cnt_reg != 8'(ACCESS_CYC - 1))
      begin
        mem_chip_en_n_o       <= 1'b0;
        mem_out_en_n_o        <= (op_reg == OP_WRITE);
        mem_write_en_n_o      <= !(op_reg == OP_WRITE);
        mem_dq_oe_o           <= (op_reg == OP_WRITE);
        upper_byte_enable_n_o <= 1'b0;
        lower_byte_enable_n_o <= 1'b0;
      end
      else
      begin
        mem_chip_en_n_o       <= 1'b1;
        mem_out_en_n_o        <= 1'b1;
        mem_write_en_n_o      <= 1'b1;
        mem_dq_oe_o           <= 1'b0;
        upper_byte_enable_n_o <= 1'b1;
        lower_byte_enable_n_o <= 1'b1;
      end
    end
  end

  // Host never pulls the busy line; it only watches it
  assign store_busy_n_o    = 1'b1;
  assign store_busy_n_oe_o = 1'b0;

endmodule

// file: verification/nvsram_ctrl_monitor.sv
// Checker on the top ports of the sequence controller.
// Assumes a single clk_i domain; bound after the module.
`timescale 1ns/1ps
module nvsram_ctrl_monitor
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_ack_o,
  input  wire logic [18:0] mem_addr_o,
  input  wire logic        mem_dq_oe_o,
  input  wire logic        mem_chip_en_n_o,
  input  wire logic        mem_out_en_n_o,
  input  wire logic        mem_write_en_n_o,
  input  wire logic        store_busy_n_i,
  input  wire logic        store_busy_n_oe_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_start;
    $fell(mem_chip_en_n_o);
  endsequence
  a_ack_one_wait: assert property (s_req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_reset_quiet: assert property ($fell(rst_i) |-> mem_chip_en_n_o
    && mem_out_en_n_o && mem_write_en_n_o && !mem_dq_oe_o && !wb_ack_o)
    else $error("strobes active out of reset");
  a_read_no_drive: assert property (!mem_out_en_n_o |-> !mem_dq_oe_o)
    else $error("data driven during a read");
  a_write_oe_high: assert property (!mem_write_en_n_o |-> mem_out_en_n_o)
    else $error("output enable low in a write");
  // Sync delay: busy must have been high before any new access
  a_wait_busy: assert property (s_start |-> $past(store_busy_n_i, 3))
    else $error("access while device busy");
  a_addr_steady: assert property (!mem_chip_en_n_o |=> $stable(mem_addr_o))
    else $error("address moved inside a cycle");
  a_cycle_ends: assert property (s_start |-> ##[1:8] mem_chip_en_n_o)
    else $error("device cycle never ended");
  a_busy_released: assert property (!store_busy_n_oe_o)
    else $error("controller drives busy line");
endmodule

bind nvsram_sequence_controller nvsram_ctrl_monitor u_nvsram_ctrl_monitor
(
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .mem_addr_o,
  .mem_dq_oe_o, .mem_chip_en_n_o, .mem_out_en_n_o, .mem_write_en_n_o,
  .store_busy_n_i, .store_busy_n_oe_o
);

// file: verification/nvsram_dev_model.sv
// Behavioural model of the non-volatile SRAM on the controller's pins.
// Assumes the bench clock for timing; only 256 words are kept.
`timescale 1ns/1ps
module nvsram_dev_model
#(
  parameter int RECALL_CYC = 100,
  parameter int STORE_CYC  = 200
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [18:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        dq_oe_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        ube_n_i,
  input  wire logic        lbe_n_i,
  output logic      [15:0] dq_o,
  output logic             busy_n_o,
  output logic             auto_o,
  output int               viol_o
);
  import nvsram_ctrl_pkg::*;
  // ----------------------------------------------------------------
  // Array, decoder and busy timer
  // ----------------------------------------------------------------
  logic [15:0] sram [256];
  logic [15:0] nv   [256];
  logic [18:0] seq  [5] = '{SEQ_ADDR_1, SEQ_ADDR_2, SEQ_ADDR_3,
                            SEQ_ADDR_4, SEQ_ADDR_5};
  logic [18:0] a_q;
  logic [15:0] junk = 16'h5a5a;
  logic        act_q = 1'b0;
  logic        wr_q = 1'b0;
  logic        dirty = 1'b0;
  int          step;
  int          cnt;
  wire  act  = !ce_n_i && (!oe_n_i || !we_n_i);
  wire  wr   = act && !we_n_i && cnt == 0;
  wire  nvsel = addr_i[14:2] == CMD_STORE[14:2]
             || addr_i[14:2] == CMD_RECALL[14:2];
  wire  drv  = act && we_n_i && cnt == 0 && !(step == 5 && nvsel);
  wire  bad  = (act && cnt > 0) || (wr && !dq_oe_i);
  assign busy_n_o = cnt == 0;
  // Undriven data lines keep toggling so stale data cannot pass
  assign dq_o = drv ? sram[addr_i[7:0]] : junk;
  initial
  begin
    foreach (nv[i]) nv[i] = 16'h0000;
    auto_o = 1'b1;
  end
  always @(posedge clk_i)
  begin
    junk <= ~junk;
    if (act) a_q <= addr_i;
    if (act) wr_q <= !we_n_i;
    act_q <= act;
    if (rst_i)
    begin
      cnt <= RECALL_CYC;
      if (auto_o && dirty) nv <= sram;
      sram <= nv;
      step <= 0;
      viol_o <= 0;
    end
    else
    begin
      viol_o <= viol_o + int'(bad);
      if (cnt > 0) cnt <= cnt - 1;
      if (wr) dirty <= 1'b1;
      if (wr && !lbe_n_i) sram[addr_i[7:0]][7:0] <= dq_i[7:0];
      if (wr && !ube_n_i) sram[addr_i[7:0]][15:8] <= dq_i[15:8];
      if (act_q && !act)
      begin
        if (wr_q) step <= 0;
        else if (step == 5)
        begin
          step <= 0;
          case (a_q[14:2])
            CMD_STORE[14:2]:
            begin
              nv    <= sram;
              cnt   <= STORE_CYC;
              dirty <= 1'b0;
            end
            CMD_RECALL[14:2]:
            begin
              sram  <= nv;
              cnt   <= RECALL_CYC;
              dirty <= 1'b0;
            end
            CMD_AS_OFF[14:2]: auto_o <= 1'b0;
            CMD_AS_ON[14:2]:  auto_o <= 1'b1;
            default:          step <= 0;
          endcase
        end
        else if (a_q[14:2] == seq[step][14:2]) step <= step + 1;
        else step <= int'(a_q[14:2] == SEQ_ADDR_1[14:2]);
      end
    end
  end
endmodule

// file: verification/tb_top.sv
// Self-checking bench: Wishbone master, device model, random data.
// Assumes the controller answers one wait state after each request.
`timescale 1ns/1ps
module tb_top;
  import nvsram_ctrl_pkg::*;
  logic        clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic [3:0]  wb_adr_i = 0, wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, dq_oe, ce_n, oe_n, we_n, ub_n, lb_n, bz_o, bz_oe;
  logic        dev_bz_n, auto;
  logic [18:0] addr;
  logic [18:0] ta [6];
  logic [15:0] dq_c, dq_d;
  logic [15:0] td [6];
  int          n_errors = 0, checks = 0, viol;
  wire         busy_n = dev_bz_n & (bz_oe ? bz_o : 1'b1);
  nvsram_sequence_controller u_nvsram_sequence_controller (.clk_i, .rst_i,
    .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .mem_addr_o(addr), .mem_dq_i(dq_d),
    .mem_dq_o(dq_c), .mem_dq_oe_o(dq_oe), .mem_chip_en_n_o(ce_n),
    .mem_out_en_n_o(oe_n), .mem_write_en_n_o(we_n),
    .upper_byte_enable_n_o(ub_n), .lower_byte_enable_n_o(lb_n),
    .store_busy_n_i(busy_n), .store_busy_n_o(bz_o), .store_busy_n_oe_o(bz_oe));
  nvsram_dev_model u_nvsram_dev_model (.clk_i, .rst_i, .addr_i(addr),
    .dq_i(dq_c), .dq_oe_i(dq_oe), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .ube_n_i(ub_n), .lbe_n_i(lb_n), .dq_o(dq_d),
    .busy_n_o(dev_bz_n), .auto_o(auto), .viol_o(viol));
  initial forever #12.5 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------
  function automatic logic f_auto(input logic cur, input logic [2:0] c);
    return c == OP_AS_OFF ? 1'b0 : (c == OP_AS_ON ? 1'b1 : cur);
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) n_errors++;
    if (g !== e) $display("BAD t=%0t got %h exp %h", $time, g, e);
  endtask
  task automatic wb(input logic [3:0] a, input logic [31:0] d,
                    input logic w, output logic [31:0] r);
    int t = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hf};
    {wb_adr_i, wb_dat_i} <= {a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++t < 50);
    r = wb_dat_o;
    if (t >= 50) n_errors++;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic wait_idle;
    logic [31:0] r;
    int t = 0;
    do wb(REG_STATUS, 0, 0, r); while (r[ST_BUSY_BIT] !== 1'b0 && ++t < 999);
    if (t >= 999) n_errors++;
  endtask
  task automatic op(input logic [2:0] c);
    logic [31:0] r;
    wb(REG_CTRL, 32'({c, 1'b1}), 1, r);
    wait_idle;
  endtask
  task automatic mw(input logic [18:0] a, input logic [15:0] d);
    logic [31:0] r;
    wb(REG_ADDR, 32'(a), 1, r);
    wb(REG_WDATA, 32'(d), 1, r);
    op(OP_WRITE);
  endtask
  task automatic mr(input logic [18:0] a, input logic [15:0] e);
    logic [31:0] r;
    wb(REG_ADDR, 32'(a), 1, r);
    op(OP_READ);
    wb(REG_RDATA, 0, 0, r);
    cmp(32'(r[15:0]), 32'(e));
  endtask
  task automatic wrap_up;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    logic        a;
    void'($urandom(32'h53c1d7cb));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(REG_STATUS, 0, 0, r);
    cmp(32'(r[ST_BUSY_BIT]), 32'h1);
    wait_idle;
    cmp(32'(auto), 32'h1);
    mr(19'h7ff3c, 16'h0000);
    $display("test powerup done");
    foreach (ta[i]) ta[i] = {16'($urandom), 3'(i)};
    foreach (td[i]) td[i] = 16'($urandom);
    td[0] = 16'hffff;
    td[1] = 16'h0000;
    foreach (ta[i]) mw(ta[i], td[i]);
    foreach (ta[i]) mr(ta[i], td[i]);
    op(OP_STORE);
    foreach (ta[i]) mr(ta[i], td[i]);
    foreach (ta[i]) mw(ta[i], ~td[i]);
    op(OP_RECALL);
    foreach (ta[i]) mr(ta[i], td[i]);
    $display("test store recall done");
    a = auto;
    foreach (ta[i]) if (i < 2) op(i == 0 ? OP_AS_OFF : OP_AS_ON);
    op(OP_AS_OFF);
    a = f_auto(f_auto(f_auto(a, OP_AS_OFF), OP_AS_ON), OP_AS_OFF);
    cmp(32'(auto), 32'(a));
    wb(REG_STATUS, 0, 0, r);
    cmp(32'(r[ST_NEED_BIT]), 32'h1);
    op(OP_AS_ON);
    cmp(32'(auto), 32'(f_auto(a, OP_AS_ON)));
    $display("test auto store done");
    wb(4'hf, 32'(~0), 1, r);
    wb(4'hf, 0, 0, r);
    cmp(r, 32'h0);
    cmp(32'(viol), 32'h0);
    $display("test unmapped done");
    wrap_up;
  end
  initial
  begin
    #2000000;
    n_errors++;
    wrap_up;
  end
endmodule
